// File: design/dcm_pkg.sv
// Package with register layout and geometry constants of the address mapper.
package dcm_pkg;
   localparam logic [3:0]  CFG_OFFSET       = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
   localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
   localparam logic [31:0] CFG_WRITE_MASK   = 32'h0000_DFDF;
   localparam int          UPPER_BASE       = 8;
   localparam int          LOWER_BASE       = 0;
   localparam int          FLD_ACCESS_ON    = 0;
   localparam int          FLD_STD_GEOM     = 1;
   localparam int          FLD_SIZE_LO      = 2;
   localparam int          FLD_DUAL_X16     = 4;
   localparam int          FLD_INTLV_LO     = 6;
   localparam logic [1:0]  INTLV_FOUR       = 2'h0;
   localparam logic [1:0]  INTLV_TWO        = 2'h1;
   localparam logic [1:0]  INTLV_NONE       = 2'h2;
   localparam logic [1:0]  INTLV_SPLIT      = 2'h3;
   localparam int          BYTE_BITS        = 2;
   localparam int          SYS_ADDR_W       = 29;
   localparam int          ROW_W            = 14;
   localparam int          COL_W            = 11;
   localparam int          BANK_W           = 2;
   localparam logic [4:0]  BASE_ROW_W       = 5'h0C;
   localparam logic [4:0]  BASE_COL_W       = 5'h08;
endpackage : dcm_pkg

// File: design/dcm_select_map.sv
// One chip select's split of a local address into row, bank and column.
`timescale 1ns/1ns
module dcm_select_map
   import dcm_pkg::*;
(
   input  wire logic [7:0]            cfg_i,
   input  wire logic [SYS_ADDR_W-1:0] addr_i,
   output logic      [ROW_W-1:0]      row_o,
   output logic      [BANK_W-1:0]     bank_o,
   output logic      [COL_W-1:0]      col_o,
   output logic      [4:0]            span_o
);
   logic [1:0] size;
   logic [1:0] intlv;
   logic       std;
   logic       dual;
   logic [4:0] row_w;
   logic [4:0] col_w;
   logic [SYS_ADDR_W-1:0] word;
   logic [SYS_ADDR_W-1:0] rest;
   assign size  = cfg_i[FLD_SIZE_LO +: 2];
   assign intlv = cfg_i[FLD_INTLV_LO +: 2];
   assign std   = cfg_i[FLD_STD_GEOM];
   assign dual  = cfg_i[FLD_DUAL_X16];

   logic [2:0] eff;

   function automatic logic [4:0] step(input logic hit);
      step = hit ? 5'h01 : 5'h00;
   endfunction

   // A pair of x16 parts addresses like one x32 part a size step up.
   assign eff = {1'b0, size} + {2'h0, dual};

   // Standard bodies widen the column first; others widen the row.
   always_comb begin
      if (std) begin
         row_w = BASE_ROW_W + step(eff >= 3'h2);
         col_w = BASE_COL_W + step(eff >= 3'h1) + step(eff >= 3'h3)
               + step(eff >= 3'h4);
      end else begin
         row_w = BASE_ROW_W + step(eff >= 3'h1) + step(eff >= 3'h2);
         col_w = BASE_COL_W + step(eff >= 3'h3) + step(eff >= 3'h4);
      end
      // Two bank bits and two byte bits sit beside row and column.
      span_o = row_w + col_w + 5'h04;
   end

   // Column, then interleaved banks, then row, then any separate banks.
   always_comb begin
      word   = addr_i >> BYTE_BITS;
      col_o  = COL_W'(word & ((SYS_ADDR_W'(1) << col_w) - SYS_ADDR_W'(1)));
      rest   = word >> col_w;
      bank_o = 2'h0;
      case (intlv)
         INTLV_FOUR: begin
            bank_o = rest[1:0];
            rest   = rest >> 2;
         end
         INTLV_TWO, INTLV_SPLIT: begin
            bank_o[0] = rest[0];
            rest      = rest >> 1;
         end
         default: ;
      endcase
      row_o = ROW_W'(rest & ((SYS_ADDR_W'(1) << row_w) - SYS_ADDR_W'(1)));
      rest  = rest >> row_w;
      case (intlv)
         INTLV_NONE:  bank_o = rest[1:0];
         INTLV_TWO,
         INTLV_SPLIT: bank_o[1] = rest[0];
         default: ;
      endcase
   end
endmodule // dcm_select_map

// File: design/dcm_mapper.sv
// Wishbone configuration register and two chip select address mapper.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Contract
// - Upper select interleave field picks bank scheme.
// - Lower select interleave same encoding, resets zero.
// - Upper dual bit selects two x16 devices.
// - Lower dual bit selects two x16, resets zero.
// - Upper size field sets density and widths.
// - Lower size field same encoding, resets zero.
// - Geometry bit picks standard or non-standard widths.
// - Upper access only while its enable set.
// - Lower access only while its enable set.
// - Reserved configuration bits always read zero.
// - Each select maps with its own settings.
// - Full interleave puts banks above column.
module dcm_mapper
   import dcm_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [3:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  req_valid_i,
   input  wire logic [SYS_ADDR_W-1:0] req_addr_i,
   output logic                       mem_valid_o,
   output logic                       mem_select_o,
   output logic      [ROW_W-1:0]      mem_row_o,
   output logic      [BANK_W-1:0]     mem_bank_o,
   output logic      [COL_W-1:0]      mem_col_o,
   output logic                       req_refused_o
);
   logic [31:0]           cfg_reg;
   logic [31:0]           cfg_next;
   logic                  ack_reg;
   logic [31:0]           dat_reg;
   logic                  refused_seen_reg;
   logic                  bus_go;
   logic [ROW_W-1:0]      row_lo;
   logic [ROW_W-1:0]      row_up;
   logic [BANK_W-1:0]     bank_lo;
   logic [BANK_W-1:0]     bank_up;
   logic [COL_W-1:0]      col_lo;
   logic [COL_W-1:0]      col_up;
   logic [4:0]            span_lo;
   logic [SYS_ADDR_W-1:0] local_up;
   logic                  hit_up;
   logic                  sel_on;

   assign bus_go = wb_cyc_i && wb_stb_i && !ack_reg;

   // Byte lanes merge into the writable bits only; reserved stay zero.
   always_comb begin
      cfg_next = cfg_reg;
      for (int i = 0; i < 4; i++) begin
         if (wb_sel_i[i]) cfg_next[8*i +: 8] = wb_dat_i[8*i +: 8];
      end
      cfg_next = cfg_next & CFG_WRITE_MASK;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= CFG_RESET;
      end else if (bus_go && wb_we_i && wb_adr_i == CFG_OFFSET) begin
         cfg_reg <= cfg_next;
      end
   end

   // Unmapped offsets read zero so a stray read cannot leak state.
   function automatic logic [31:0] read_word(input logic [3:0]  adr,
                                             input logic [31:0] cfg,
                                             input logic        flag);
      case (adr)
         CFG_OFFSET:    read_word = cfg & CFG_WRITE_MASK;
         STATUS_OFFSET: read_word = {31'h0, flag};
         default:       read_word = 32'h0000_0000;
      endcase
   endfunction

   // Ack comes one cycle after the strobe and drops the cycle after.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_go;
      end
   end

   // Read data is captured at the taken edge and stands until the next read.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= 32'h0000_0000;
      end else if (bus_go && !wb_we_i) begin
         dat_reg <= read_word(wb_adr_i, cfg_reg, refused_seen_reg);
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // Each instance sees only its own byte of the configuration.
   dcm_select_map u_lower (
      .cfg_i  (cfg_reg[LOWER_BASE +: 8]),
      .addr_i (req_addr_i),
      .row_o  (row_lo),
      .bank_o (bank_lo),
      .col_o  (col_lo),
      .span_o (span_lo)
   );

   // The upper select begins where the lower select's span ends.
   assign hit_up   = (req_addr_i >> span_lo) != '0;
   assign local_up = req_addr_i - (SYS_ADDR_W'(1) << span_lo);

   dcm_select_map u_upper (
      .cfg_i  (cfg_reg[UPPER_BASE +: 8]),
      .addr_i (local_up),
      .row_o  (row_up),
      .bank_o (bank_up),
      .col_o  (col_up),
      .span_o ()
   );

   // Only the decoded select's own enable bit gates the request.
   function automatic logic select_on(input logic [31:0] cfg,
                                      input logic        up);
      select_on = up ? cfg[UPPER_BASE + FLD_ACCESS_ON]
                     : cfg[LOWER_BASE + FLD_ACCESS_ON];
   endfunction

   assign sel_on = select_on(cfg_reg, hit_up);

   // A request to a disabled select gives no memory pulse at all.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_valid_o <= 1'b0;
      end else begin
         mem_valid_o <= req_valid_i && sel_on;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_refused_o <= 1'b0;
      end else begin
         req_refused_o <= req_valid_i && !sel_on;
      end
   end

   // The flag is sticky because software may poll long after the event.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refused_seen_reg <= 1'b0;
      end else if (req_valid_i && !sel_on) begin
         refused_seen_reg <= 1'b1;
      end
   end

   // Fields hold between requests so the sequencer may sample them late.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_select_o <= 1'b0;
      end else if (req_valid_i) begin
         mem_select_o <= hit_up;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_row_o <= '0;
      end else if (req_valid_i) begin
         mem_row_o <= hit_up ? row_up : row_lo;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_bank_o <= '0;
      end else if (req_valid_i) begin
         mem_bank_o <= hit_up ? bank_up : bank_lo;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_col_o <= '0;
      end else if (req_valid_i) begin
         mem_col_o <= hit_up ? col_up : col_lo;
      end
   end

   // Register side checks.
   a_reserved_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (cfg_reg & ~CFG_WRITE_MASK) == 32'h0
   ) else $error("reserved bit set");

   a_read_reserved: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (wb_dat_o & ~CFG_WRITE_MASK) == 32'h0
   ) else $error("reserved bit read as one");

   a_write_lands: assert property (
      @(posedge clk_i) disable iff (rst_i)
      bus_go && wb_we_i && wb_adr_i == CFG_OFFSET && wb_sel_i == 4'hF
      |=> cfg_reg == ($past(wb_dat_i) & CFG_WRITE_MASK)
   ) else $error("configuration write lost");

   a_cfg_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !(bus_go && wb_we_i) |=> $stable(cfg_reg)
   ) else $error("configuration changed without a write");

   a_ack_one_cycle: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o
   ) else $error("ack held too long");

   a_ack_after_take: assert property (
      @(posedge clk_i) disable iff (rst_i)
      bus_go |=> wb_ack_o
   ) else $error("taken request not acknowledged");

   a_ack_needs_take: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(bus_go)
   ) else $error("ack without a request");

   a_status_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(!wb_we_i && wb_adr_i == STATUS_OFFSET)
      |-> wb_dat_o == {31'h0, $past(refused_seen_reg)}
   ) else $error("status read wrong");

   // Request side checks.
   a_lower_gate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      mem_valid_o && !mem_select_o |-> $past(cfg_reg[LOWER_BASE])
   ) else $error("lower select issued while disabled");

   a_upper_gate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      mem_valid_o && mem_select_o |-> $past(cfg_reg[UPPER_BASE])
   ) else $error("upper select issued while disabled");

   a_refused_not_issued: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_refused_o |-> !mem_valid_o
   ) else $error("refused request was issued");

   a_issue_answer: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_valid_i |=> mem_valid_o != req_refused_o
   ) else $error("request not answered exactly once");

   a_no_stray_issue: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !req_valid_i |=> !mem_valid_o && !req_refused_o
   ) else $error("answer without a request");

   a_refuse_cause: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_refused_o |-> !$past(sel_on)
   ) else $error("enabled select refused");

   a_refused_sticky: assert property (
      @(posedge clk_i) disable iff (rst_i)
      refused_seen_reg |=> refused_seen_reg
   ) else $error("refused flag cleared");

   a_refused_flags: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_refused_o |-> refused_seen_reg
   ) else $error("refused flag not set");

   // Field holding checks.
   a_select_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !req_valid_i |=> $stable(mem_select_o)
   ) else $error("select moved without a request");

   a_row_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !req_valid_i |=> $stable(mem_row_o)
   ) else $error("row moved without a request");

   a_bank_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !req_valid_i |=> $stable(mem_bank_o)
   ) else $error("bank moved without a request");

   a_col_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !req_valid_i |=> $stable(mem_col_o)
   ) else $error("column moved without a request");
endmodule // dcm_mapper

// File: tb/dcm_ddr_model.sv
// Behavioural model of the memory devices on the two chip selects.
`timescale 1ns/1ns
module dcm_ddr_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic valid_i,
   input  wire logic select_i,
   output int        lower_o,
   output int        upper_o
);
   // Counting issues per select shows a disabled select staying idle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_o <= 0;
         upper_o <= 0;
      end else if (valid_i && select_i) begin
         upper_o <= upper_o + 1;
      end else if (valid_i) begin
         lower_o <= lower_o + 1;
      end
   end
endmodule // dcm_ddr_model

// File: tb/tb.sv
// Self-checking bench of the address mapper.
`timescale 1ns/1ns
module tb;
   import dcm_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, rv = 0;
   logic [3:0]  adr = 4'h0, sel = 4'hF;
   logic [31:0] wdat = 32'h0, d, wb_dat_o;
   logic [28:0] ra = 29'h0, base_a = 29'h01B3C6A4, ua;
   logic        wb_ack_o, mem_valid_o, mem_select_o, req_refused_o;
   logic [13:0] mem_row_o;
   logic [1:0]  mem_bank_o, m;
   logic [10:0] mem_col_o;
   int          err_total = 0, comparisons = 0, lo, up;
   logic [7:0]  gc [5] = '{8'h0F, 8'h1B, 8'h0D, 8'h19, 8'h1F};
   int          gw [5] = '{10, 10, 9, 9, 11};
   int          gr [5] = '{13, 13, 14, 14, 13};
   always #20 clk_i = ~clk_i;
   dcm_mapper DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .req_valid_i(rv), .req_addr_i(ra), .mem_valid_o(mem_valid_o),
      .mem_select_o(mem_select_o), .mem_row_o(mem_row_o),
      .mem_bank_o(mem_bank_o), .mem_col_o(mem_col_o),
      .req_refused_o(req_refused_o));
   dcm_ddr_model mem (.clk_i(clk_i), .rst_i(rst_i), .valid_i(mem_valid_o),
      .select_i(mem_select_o), .lower_o(lo), .upper_o(up));
   task automatic finish_test;
      $display("compares=%0d errors=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      cyc <= 1;
      we <= w;
      adr <= a;
      wdat <= wd;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      rd = wb_dat_o;
      cyc <= 0;
      if (n == 20) begin
         err_total++;
         finish_test();
      end
   endtask
   // Widths cw and rw are the expected column and row sizes.
   task automatic req(input logic [28:0] a, input logic [1:0] m, input int cw,
                      input int rw, input logic s, input logic rf);
      logic [31:0] r, b;
      int n;
      b = a >> (cw + 2);
      r = a >> (cw + 4);
      if (m == INTLV_NONE) begin
         r = a >> (cw + 2);
         b = a >> (cw + rw + 2);
      end else if (m != INTLV_FOUR) begin
         r = a >> (cw + 3);
         b = {30'h0, a[cw + rw + 3], a[cw + 2]};
      end
      @(posedge clk_i);
      rv <= 1;
      ra <= a;
      @(posedge clk_i);
      rv <= 0;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (mem_valid_o === 1'b1 || req_refused_o === 1'b1) break;
      end
      if (n == 20) begin
         err_total++;
         finish_test();
      end
      chk(32'(req_refused_o), 32'(rf));
      if (!rf) begin
         chk(32'(mem_select_o), 32'(s));
         chk(32'(mem_row_o), r & ((32'h1 << rw) - 1));
         chk(32'(mem_bank_o), b & 32'h3);
         chk(32'(mem_col_o), (a >> 2) & ((32'h1 << cw) - 1));
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      wb(0, CFG_OFFSET, 0, d);
      chk(d, CFG_RESET);
      req(base_a, 0, 9, 12, 0, 1);
      wb(0, STATUS_OFFSET, 0, d);
      chk(d, 32'h1);
      wb(1, CFG_OFFSET, 32'hFFFFFFFF, d);
      wb(0, CFG_OFFSET, 0, d);
      chk(d, 32'h0000DFDF);
      wb(0, 4'h8, 0, d);
      chk(d, 32'h0);
      // Every interleave mode on the lower select, its complement on the upper.
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         wb(1, CFG_OFFSET, {16'h0, ~m, 6'h07, m, 6'h07}, d);
         req(base_a, m, 9, 12, 0, 0);
         req(base_a | 29'h2000000, ~m, 9, 12, 1, 0);
      end
      for (int i = 0; i < 5; i++) begin
         wb(1, CFG_OFFSET, {16'h0, gc[i], gc[i]}, d);
         req(base_a, 0, gw[i], gr[i], 0, 0);
         ua = base_a + (29'h1 << (gw[i] + gr[i] + 4));
         req(ua, 0, gw[i], gr[i], 1, 0);
      end
      sel <= 4'h2;
      wb(1, CFG_OFFSET, 32'hFFFF0000, d);
      sel <= 4'hF;
      wb(0, CFG_OFFSET, 0, d);
      chk(d, 32'h0000001F);
      wb(1, CFG_OFFSET, 32'h00000007, d);
      req(base_a | 29'h2000000, 0, 9, 12, 1, 1);
      repeat (2) @(posedge clk_i);
      chk(32'(lo), 32'h9);
      chk(32'(up), 32'h9);
      finish_test();
   end
endmodule // tb
